// [dv/hsc_checker.sv]
`timescale 1ns/1ns
`include "hsc_defines.vh"
module hsc_checker (
  input wire ref_clk,
  input wire rst_n,
  input wire enc_a,
  input wire enc_b,
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire compare_result
);
  logic aw_got, w_got, cmd_pend, pa, pb; // write progress, last pin levels
  logic [5:0] ar_addr; // address of the read in flight
  logic [3:0] age; // clocks since a pin moved, saturating
  // bookkeeping so that answers can be tied to their requests
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {aw_got, w_got, cmd_pend, pa, pb, ar_addr} <= 11'h0;
      age <= 4'hf;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        cmd_pend <= s_axi_awaddr == `HSC_OFF_CMP_CMD;
      end
      if (s_axi_wvalid && s_axi_wready) w_got <= 1'b1;
      if (s_axi_bvalid && s_axi_bready) {aw_got, w_got, cmd_pend} <= 3'h0;
      if (s_axi_arvalid && s_axi_arready) ar_addr <= s_axi_araddr;
      {pa, pb} <= {enc_a, enc_b};
      age <= ({pa, pb} != {enc_a, enc_b}) ? 4'h0 : age + {3'h0, age != 4'hf};
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_b_wait;
    aw_got && w_got && !s_axi_bvalid;
  endsequence
  a_read_answer: assert property (s_ar_taken |-> ##[1:2] s_axi_rvalid)
    else $error("read not answered");
  a_write_answer: assert property (s_b_wait |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  a_resp_after_both: assert property (s_axi_bvalid |-> aw_got && w_got)
    else $error("write answered early");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_aligned_okay: assert property (s_axi_rvalid && ar_addr[1:0] == 2'h0 &&
    ar_addr <= `HSC_OFF_CMP_CMD |-> s_axi_rresp == `HSC_RESP_OKAY)
    else $error("mapped read refused");
  a_odd_refused: assert property (s_axi_rvalid && ar_addr[1:0] != 2'h0 |->
    s_axi_rresp == `HSC_RESP_SLVERR) else $error("misaligned read accepted");
  a_result_sticky: assert property ($fell(compare_result) |-> $past(cmd_pend))
    else $error("compare result dropped without rearm");
  a_result_cause: assert property ($rose(compare_result) |-> age <= 4'h8)
    else $error("compare result rose with no pin edge");
endmodule // hsc_checker
bind hsc_counter hsc_checker u_chk (.*);

// [dv/hsc_enc_model.sv]
`timescale 1ns/1ns
// encoder stand-in: one pin edge every four clocks, still between bursts
module hsc_enc_model (
  input wire ref_clk,
  output logic enc_a,
  output logic enc_b
);
  initial {enc_a, enc_b} = 2'h0;
  // quad: a leads when lvl is high; else pulses on a, b held as a level
  task move(input logic q, input int n, input logic lvl);
    if (!q) enc_b <= lvl;
    repeat (q ? n : 2 * n) begin
      repeat (4) @(posedge ref_clk);
      if (!q || lvl == (enc_a == enc_b)) enc_a <= ~enc_a;
      else enc_b <= ~enc_b;
    end
    // slack for the synchroniser and decode latency
    repeat (8) @(posedge ref_clk);
  endtask
endmodule // hsc_enc_model

// [dv/tb_top.sv]
`timescale 1ns/1ns
`include "hsc_defines.vh"
module tb_top;
  logic ref_clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, compare_result;
  logic irq;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  wire enc_a, enc_b; // driven by the encoder model
  int num_errors, n_checks;
  hsc_counter DUT (.*);
  hsc_enc_model enc (.ref_clk, .enc_a, .enc_b);
  // 250 mhz clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  // hang guard, far beyond the several hundred clocks the run needs
  initial begin
    repeat (20000) @(posedge ref_clk);
    num_errors++;
    finish_test;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task finish_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // address and data offered together, each dropped once taken
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    // one spare edge so registered flags settle before a check
    @(posedge ref_clk);
  endtask
  task rd(input logic [5:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // move the pins, then read the count back as two half words
  task pc(input logic q, input int n, input logic lvl, input logic [31:0] e);
    logic [31:0] lo;
    enc.move(q, n, lvl);
    rd(`HSC_OFF_CNT_LO, lo);
    rd(`HSC_OFF_CNT_HI, v);
    chk({v[15:0], lo[15:0]}, e);
  endtask
  // every input mode, both directions
  task t_modes;
    wr(`HSC_OFF_MODE, 32'h0);
    chk(r, `HSC_RESP_OKAY);
    wr(`HSC_OFF_CTRL, 32'ha);
    pc(1'b1, 10, 1'b1, 32'd10);
    pc(1'b1, 3, 1'b0, 32'd7);
    wr(`HSC_OFF_MODE, 32'h1);
    pc(1'b0, 4, 1'b0, 32'd11);
    pc(1'b0, 4, 1'b1, 32'd7);
    wr(`HSC_OFF_MODE, 32'h2);
    pc(1'b0, 3, 1'b1, 32'd10);
    wr(`HSC_OFF_CTRL, 32'hb);
    pc(1'b0, 3, 1'b0, 32'd7);
    wr(`HSC_OFF_MODE, 32'h3);
    pc(1'b0, 2, 1'b0, 32'd7);
    wr(`HSC_OFF_MODE, 32'h2);
  endtask
  // enable gates counting, start needs enable, clear beats pulses
  task t_gate;
    wr(`HSC_OFF_CTRL, 32'h0);
    pc(1'b0, 2, 1'b0, 32'd7);
    wr(`HSC_OFF_CTRL, 32'h8);
    wr(`HSC_OFF_CTRL, 32'h2);
    pc(1'b0, 2, 1'b0, 32'd7);
    wr(`HSC_OFF_CTRL, 32'he);
    pc(1'b0, 2, 1'b0, 32'h0);
    wr(`HSC_OFF_CTRL, 32'hb);
    pc(1'b0, 1, 1'b0, 32'hffffffff);
  endtask
  // target loaded first, compare armed by a rising command bit
  task t_cmp;
    wr(`HSC_OFF_CTRL, 32'h4);
    wr(`HSC_OFF_TARGET, 32'h3);
    wr(`HSC_OFF_CMP_CMD, 32'h0);
    wr(`HSC_OFF_CMP_CMD, 32'h1);
    wr(`HSC_OFF_CTRL, 32'ha);
    pc(1'b0, 2, 1'b0, 32'd2);
    chk(compare_result, 1'b0);
    pc(1'b0, 2, 1'b0, 32'd4);
    chk(compare_result, 1'b1);
    rd(`HSC_OFF_STATUS, v);
    chk(v[1:0], 2'h3);
    wr(`HSC_OFF_IRQ_EN, 32'h0);
    chk(irq, 1'b0);
    wr(`HSC_OFF_IRQ_EN, 32'h1);
    chk(irq, 1'b1);
    wr(`HSC_OFF_IRQ_CLR, 32'h3);
    chk(irq, 1'b0);
    wr(`HSC_OFF_CMP_CMD, 32'h0);
    wr(`HSC_OFF_CMP_CMD, 32'h1);
    chk(compare_result, 1'b0);
    wr(`HSC_OFF_CTRL, 32'hb);
    pc(1'b0, 1, 1'b0, 32'd3);
    chk(compare_result, 1'b1);
  endtask
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, rst_n} = '0;
    s_axi_wstrb = 4'hf;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(`HSC_OFF_STATUS, v);
    chk(v, 32'h0);
    chk(r, `HSC_RESP_OKAY);
    rd(6'h1e, v);
    chk(r, `HSC_RESP_SLVERR);
    rd(6'h24, v);
    chk(r, `HSC_RESP_SLVERR);
    wr(6'h24, 32'hf);
    chk(r, `HSC_RESP_SLVERR);
    rd(`HSC_OFF_CTRL, v);
    chk(v, 32'h0);
    t_modes;
    t_gate;
    t_cmp;
    finish_test;
  end
endmodule // tb_top

// [rtl/hsc_counter.v]
// Overview of operation
// - mode word selects three input modes
// - mode 0 counts a/b two-phase pair
// - mode 1: a pulses, b sets direction
// - mode 2: a pulses, flag sets direction
// - direction flag off up, on down
// - counts only while enabled, else holds
// - clear flag zeroes the count
// - start flag effective only while enabled
// - match status when count equals target
// - count readable as low/high words
// - arrival onto target latches result output
// - compare armed on command rising edge
`timescale 1ns/1ns
`include "hsc_defines.vh"
module hsc_counter (
  // single clock, asynchronous active-low reset
  input wire ref_clk,
  input wire rst_n,
  // encoder pins, asynchronous to ref_clk
  input wire enc_a,
  input wire enc_b,
  // write address channel; six bits reach the ninth word offset
  input wire [5:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // write data channel
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // write response channel
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // read address channel
  input wire [5:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // read data channel
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // latched compare result and level interrupt
  output reg compare_result,
  output reg irq
);
  // register map, byte offsets:
  //   0x00 control: start b3, clear b2, enable b1, down b0
  //   0x04 input mode, 0x08 target, 0x0c/0x10 count low/high half
  //   0x14 status: running b3, armed b2, result event b1, match event b0
  //   0x18 interrupt enable, 0x1c interrupt clear (reads zero)
  //   0x20 compare command: result b1 (read only), arm b0
  // software-visible state
  reg [`HSC_CTRL_W-1:0] ctrl; // down, enable, clear, start
  reg [1:0] input_mode_word; // input mode select
  reg [31:0] target; // compare value
  reg cmd_arm; // compare command condition level
  reg cmd_arm_q; // previous condition, for edge
  reg cmp_active; // comparison running
  reg running; // start taken while enabled
  reg [31:0] hs_count_value; // the count itself
  reg [`HSC_ST_W-1:0] status; // sticky events
  reg [`HSC_ST_W-1:0] irq_en; // interrupt enables
  reg match_q; // previous equality, for event edge
  // write channel holding: each half parks here until its partner arrives
  reg [5:0] aw_addr; // captured write address
  reg aw_full; // address parked
  reg [31:0] w_data; // captured write data
  reg [3:0] w_strb; // captured byte lanes
  reg w_full; // data parked
  // decode outputs and combinational helpers
  wire step; // one counted edge this cycle
  wire step_down; // direction of that edge
  wire wr_fire; // parked write commits now
  wire [31:0] next_count; // count after the pending step
  wire count_eq; // count sits on the target
  wire arrive; // a counted step lands on the target
  wire [`HSC_ST_W-1:0] ev; // event bits raised this cycle
  reg [`HSC_ST_W-1:0] clr_mask; // bits software clears this cycle

  // address decode helper, shared by read and write sides
  // holes and misaligned offsets fall outside this list and answer slverr
  function known_addr;
    input [5:0] a;
    begin
      known_addr = (a == `HSC_OFF_CTRL) || (a == `HSC_OFF_MODE) ||
                   (a == `HSC_OFF_TARGET) || (a == `HSC_OFF_CNT_LO) ||
                   (a == `HSC_OFF_CNT_HI) || (a == `HSC_OFF_STATUS) ||
                   (a == `HSC_OFF_IRQ_EN) || (a == `HSC_OFF_IRQ_CLR) ||
                   (a == `HSC_OFF_CMP_CMD);
    end
  endfunction

  // pin synchronising and mode decode
  // pin to count takes four clocks; edges closer than one clock can be lost
  hsc_input_decode u_dec (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .a_in(enc_a),
    .b_in(enc_b),
    .mode(input_mode_word),
    .down_flag(ctrl[`HSC_CTRL_DOWN]),
    .step(step),
    .step_down(step_down)
  );

  // write fires once both address and data are held and no response pends
  // holding off while bvalid stands keeps a second write from overrunning
  assign wr_fire = aw_full & w_full & ~s_axi_bvalid;

  // up or down by one; wraps modulo 2^32
  // no saturation: a run down from zero wraps to all ones
  assign next_count = step_down ? hs_count_value - 32'h0000_0001 :
                      hs_count_value + 32'h0000_0001;

  assign count_eq = (hs_count_value == target);
  // neighbour-step arrival: only a real step onto the target counts;
  // a held clear swallows the step, so it swallows the arrival too
  assign arrive = cmp_active & step & ctrl[`HSC_CTRL_ENABLE] & running &
                  ~ctrl[`HSC_CTRL_CLEAR] & (next_count == target);
  // bit 1: arrival event, bit 0: equality became true
  assign ev = {arrive, count_eq & ~match_q};

  // aw/w capture, either order, one write at a time
  // either channel may arrive first; both park until the pair is complete
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 6'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      // ready is registered and would lag the full flag by one edge;
      // the handshake term drops it at once so nothing is taken twice
      s_axi_awready <= ~aw_full & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready <= ~w_full & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response; unmapped addresses answer slverr
  // unmapped writes still complete, with no side effect
  // bvalid stands until bready is sampled high
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `HSC_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= known_addr(aw_addr) ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; low byte lane carries all control fields
  // a write with lane 0 off leaves every control field untouched
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= {`HSC_CTRL_W{1'b0}};
      input_mode_word <= `HSC_MODE_QUAD;
      target <= 32'h0000_0000;
      cmd_arm <= 1'b0;
      irq_en <= {`HSC_ST_W{1'b0}};
    end else begin
      if (wr_fire && w_strb[0]) begin
        case (aw_addr)
          `HSC_OFF_CTRL: ctrl <= w_data[`HSC_CTRL_W-1:0];
          `HSC_OFF_MODE: input_mode_word <= w_data[1:0];
          `HSC_OFF_IRQ_EN: irq_en <= w_data[`HSC_ST_W-1:0];
          `HSC_OFF_CMP_CMD: cmd_arm <= w_data[`HSC_CMD_ARM];
          default: begin
            // other offsets handled elsewhere or ignored
          end
        endcase
      end
      // target written per byte lane so partial loads work
      // target may change while armed; the next arrival uses the new value
      if (wr_fire && aw_addr == `HSC_OFF_TARGET) begin
        if (w_strb[0]) target[7:0] <= w_data[7:0];
        if (w_strb[1]) target[15:8] <= w_data[15:8];
        if (w_strb[2]) target[23:16] <= w_data[23:16];
        if (w_strb[3]) target[31:24] <= w_data[31:24];
      end
    end
  end

  // the counter: clear first, then enabled counting
  // clear is a level: the count stays at zero for as long as it is set
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hs_count_value <= 32'h0000_0000;
      running <= 1'b0;
    end else begin
      // start only latches while enable is on; dropping enable stops it
      // running survives start going low, so start acts as a request
      if (!ctrl[`HSC_CTRL_ENABLE])
        running <= 1'b0;
      else if (ctrl[`HSC_CTRL_START])
        running <= 1'b1;
      if (ctrl[`HSC_CTRL_CLEAR])
        hs_count_value <= 32'h0000_0000;
      else if (ctrl[`HSC_CTRL_ENABLE] && running && step)
        hs_count_value <= next_count;
    end
  end

  // compare arming on a rising condition; result latches on arrival
  // arming again clears the result; nothing else ever drops it
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_arm_q <= 1'b0;
      cmp_active <= 1'b0;
      compare_result <= 1'b0;
      // count and target both reset to zero, so equality starts out true;
      // seeding the detector high avoids a false match event after reset
      match_q <= 1'b1;
    end else begin
      cmd_arm_q <= cmd_arm;
      match_q <= count_eq;
      if (cmd_arm & ~cmd_arm_q) begin
        cmp_active <= 1'b1;
        compare_result <= 1'b0;
      end else if (arrive & ~ctrl[`HSC_CTRL_CLEAR]) begin
        compare_result <= 1'b1;
      end
    end
  end

  // clear mask from a write to the clear register
  // only a lane-0 write to the clear offset clears anything
  always @* begin
    clr_mask = {`HSC_ST_W{1'b0}};
    if (wr_fire && aw_addr == `HSC_OFF_IRQ_CLR && w_strb[0])
      clr_mask = w_data[`HSC_ST_W-1:0];
  end

  // sticky status: a new event wins over a same-cycle clear
  // irq uses the next status so it follows status with no extra lag
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= {`HSC_ST_W{1'b0}};
      irq <= 1'b0;
    end else begin
      status <= (status & ~clr_mask) | ev;
      irq <= |(((status & ~clr_mask) | ev) & irq_en);
    end
  end

  // read channel, one beat at a time
  // arready stays low while rvalid stands: one read in flight
  // count halves are not snapshotted; read high, low, high for coherency
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `HSC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= known_addr(s_axi_araddr) ? `HSC_RESP_OKAY : `HSC_RESP_SLVERR;
        case (s_axi_araddr)
          `HSC_OFF_CTRL: s_axi_rdata <= {28'h0000000, ctrl};
          `HSC_OFF_MODE: s_axi_rdata <= {30'h00000000, input_mode_word};
          `HSC_OFF_TARGET: s_axi_rdata <= target;
          `HSC_OFF_CNT_LO: s_axi_rdata <= {16'h0000, hs_count_value[15:0]};
          `HSC_OFF_CNT_HI: s_axi_rdata <= {16'h0000, hs_count_value[31:16]};
          `HSC_OFF_STATUS: s_axi_rdata <= {28'h0000000, running, cmp_active, status};
          `HSC_OFF_IRQ_EN: s_axi_rdata <= {30'h00000000, irq_en};
          `HSC_OFF_CMP_CMD: s_axi_rdata <= {30'h00000000, compare_result, cmd_arm};
          default: s_axi_rdata <= 32'h0000_0000; // clear reg and holes read zero
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule // hsc_counter

// [rtl/hsc_defines.vh]
`ifndef HSC_DEFINES_VH
`define HSC_DEFINES_VH
// register byte offsets
`define HSC_OFF_CTRL 6'h00
`define HSC_OFF_MODE 6'h04
`define HSC_OFF_TARGET 6'h08
`define HSC_OFF_CNT_LO 6'h0c
`define HSC_OFF_CNT_HI 6'h10
`define HSC_OFF_STATUS 6'h14
`define HSC_OFF_IRQ_EN 6'h18
`define HSC_OFF_IRQ_CLR 6'h1c
`define HSC_OFF_CMP_CMD 6'h20
// control register bit positions
`define HSC_CTRL_DOWN 0
`define HSC_CTRL_ENABLE 1
`define HSC_CTRL_CLEAR 2
`define HSC_CTRL_START 3
`define HSC_CTRL_W 4
// compare command register bit: arm condition
`define HSC_CMD_ARM 0
// input mode encodings
`define HSC_MODE_QUAD 2'h0
`define HSC_MODE_PDIR 2'h1
`define HSC_MODE_PFLAG 2'h2
// status / interrupt bits
`define HSC_ST_MATCH 0
`define HSC_ST_RESULT 1
`define HSC_ST_W 2
// axi responses
`define HSC_RESP_OKAY 2'h0
`define HSC_RESP_SLVERR 2'h2
`endif

// [rtl/hsc_input_decode.v]
`timescale 1ns/1ns
`include "hsc_defines.vh"
// turns synchronised a/b levels into count steps and a direction
module hsc_input_decode (
  input wire ref_clk,
  input wire rst_n,
  input wire a_in,
  input wire b_in,
  input wire [1:0] mode,
  input wire down_flag,
  output reg step,
  output reg step_down
);
  reg [1:0] a_sync; // a synchroniser
  reg [1:0] b_sync; // b synchroniser
  reg a_q; // previous synced a
  reg b_q; // previous synced b
  wire a_s;
  wire b_s;
  assign a_s = a_sync[1];
  assign b_s = b_sync[1];
  // two flops per pin; only stage two is read below
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_sync <= 2'h0;
      b_sync <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
    end else begin
      a_sync <= {a_sync[0], a_in};
      b_sync <= {b_sync[0], b_in};
      a_q <= a_s;
      b_q <= b_s;
    end
  end
  // per-mode step decode, registered
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      step <= 1'b0;
      step_down <= 1'b0;
    end else begin
      step <= 1'b0;
      step_down <= 1'b0;
      case (mode)
        `HSC_MODE_QUAD: begin
          // x4 decode: a leads b counts up, b leads a counts down
          if ((a_s ^ a_q) ^ (b_s ^ b_q)) begin
            step <= 1'b1;
            step_down <= (a_s ^ a_q) ? (a_s == b_s) : (a_s != b_s);
          end
        end
        `HSC_MODE_PDIR: begin
          // rising edge of a counts, b level picks direction
          step <= a_s & ~a_q;
          step_down <= b_s;
        end
        `HSC_MODE_PFLAG: begin
          // b ignored entirely here
          step <= a_s & ~a_q;
          step_down <= down_flag;
        end
        default: begin
          // reserved mode value: no counting
          step <= 1'b0;
        end
      endcase
    end
  end
endmodule // hsc_input_decode
